// File: pebac_eeprom_model.sv
// Purpose: behavioural parallel eeprom on the far side of the host controller
// Assumes: one page open at a time; erased bytes read 8'hff
// Notes: data pins show a changing pattern whenever not validly driven
`timescale 1ns/1ps
module pebac_eeprom_model #(
  parameter int WRITE_NS = 3000 // internal write time, ns, under 5 ms
) (
  input wire logic [15:0] addr_i, // address pins
  input wire logic sel_n_i, // select, active low
  input wire logic oe_n_i, // output drive, active low
  input wire logic we_n_i, // write strobe, active low
  input wire logic [7:0] dq_i, // data seen on the bus
  output logic [7:0] dq_o // data offered by the device
);
  logic [7:0] mem [logic [15:0]]; // stored bytes
  logic [7:0] page [logic [15:0]]; // loaded bytes awaiting the write
  logic [15:0] la = 16'h0; // latched load address
  logic [7:0] last = 8'h0; // last loaded byte
  logic wip = 1'b0; // internal write running
  int seq = 0; // load count
  realtime t_a = 0; // last address or select change
  realtime t_o = 0; // last drive fall
  always @(addr_i or sel_n_i) t_a = $realtime;
  always @(negedge oe_n_i) t_o = $realtime;
  // address taken at strobe fall, only in write mode
  always @(negedge we_n_i) if (!sel_n_i && oe_n_i) la = addr_i;
  // data taken at strobe rise; polls between loads leave the page alone
  always @(posedge we_n_i) begin
    if (!sel_n_i && oe_n_i && !wip) begin
      page[la] = dq_i;
      last = dq_i;
      seq++;
      fork
        close_page(seq);
      join_none
    end
  end
  // page closes once the load window lapses, then the self-timed write
  task automatic close_page(input int s);
    #100000;
    if (s == seq) begin
      wip = 1'b1;
      #(WRITE_NS);
      foreach (page[a]) mem[a] = page[a];
      page.delete();
      wip = 1'b0;
    end
  endtask
  // polls during a write see the last byte inverted
  function automatic logic [7:0] rd_val(input logic [15:0] a);
    if (wip || page.num() > 0) return ~last;
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // read data only after both access times, pattern otherwise
  initial begin
    dq_o = 8'h5a;
    #0.5;
    forever begin
      if (!sel_n_i && !oe_n_i && we_n_i && $realtime - t_a >= 150 && $realtime - t_o >= 80) begin
        dq_o = rd_val(addr_i);
      end else begin
        dq_o = {dq_o[6:0], ~dq_o[7]};
      end
      #1;
    end
  end
endmodule

// File: pebac_host.sv
// Purpose: host controller driving a parallel eeprom through its pins
// Assumes: 100 MHz clock; device pins sampled through two flip-flops
// Notes: one request at a time; page loads and completion polling
// Function
// - host waits 5 ms unless polling
// - byte loads spaced 0.20 to 100 us
// - byte loads are strobe writes, drive high
// - drive may pulse low between byte loads
// - polls are ordinary reads with read timing
// - wait after power-up before read, write
`timescale 1ns/1ps
module pebac_host
  import pebac_pkg::*;
#(
  parameter int AW = 16, // address width
  parameter int DW = 8, // data width
  parameter int PAGE_BYTES = 128, // bytes per page
  parameter int WRITE_WAIT = pebac_pkg::WRITE_WAIT_CYC, // internal write wait, cycles
  parameter int PU_READ = pebac_pkg::PU_READ_CYC, // power-up to read, cycles
  parameter int PU_WRITE = pebac_pkg::PU_WRITE_CYC, // power-up to write, cycles
  parameter bit USE_POLL = 1'b1 // 1 polls for completion, 0 waits
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic req_i, // request valid
  input wire logic we_i, // 1 write, 0 read
  input wire logic last_i, // write closes the page
  input wire logic [AW-1:0] addr_i, // request address
  input wire logic [DW-1:0] wdata_i, // write data
  output logic ready_o, // request taken when high with req_i, except in the cycle an open page closes on its load window
  output logic rvalid_o, // read data pulse
  output logic [DW-1:0] rdata_o, // read data
  output logic busy_o, // internal write in progress
  output logic [AW-1:0] mem_addr_o, // address pins
  output logic mem_sel_n_o, // select, active low
  output logic mem_oe_n_o, // output drive, active low
  output logic mem_we_n_o, // write strobe, active low
  input wire logic [DW-1:0] mem_dq_i, // data pins in
  output logic [DW-1:0] mem_dq_o, // data pins out
  output logic mem_dq_oe_o // data pin drive enable
);
  import pebac_pkg::*;

  localparam int TW = 20; // timer width
  initial begin
    if (WRITE_WAIT >= (1 << TW) || PU_WRITE >= (1 << TW) || PU_READ >= (1 << TW)) begin
      $error("pebac_host: count exceeds timer");
    end
    if (PAGE_BYTES < 2 || PAGE_BYTES > (1 << AW) || DW < 8) $error("pebac_host: bad geometry");
  end

  pebac_state_t st_q, st_d; // controller state
  logic [AW-1:0] addr_q, addr_d; // address pins
  logic [DW-1:0] wd_q, wd_d; // write data pins
  logic [DW-1:0] last_wd_q, last_wd_d; // last byte written, for polling
  logic [DW-1:0] rd_q, rd_d; // read data
  logic sel_n_q, sel_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dqoe_q, dqoe_d; // pin drive
  logic rv_q, rv_d; // read valid pulse
  logic page_q, page_d; // page open
  logic close_q, close_d; // current load closes page
  logic poll_q, poll_d; // current read is a completion poll
  logic [TW-1:0] win_q, win_d; // cycles since last load or poll
  logic [TW-1:0] pu_q, pu_d; // power-up count
  logic load; // timer load
  logic [TW-1:0] tval; // timer value
  logic tdone; // timer expired
  logic [DW-1:0] dq_s1_q, dq_s2_q; // data pin synchroniser
  logic rd_ok, wr_ok; // power-up waits passed

  // two flip-flop synchroniser on the data pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  pebac_timer #(.W(TW)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load),
    .value_i(tval),
    .done_o(tdone)
  );

  assign rd_ok = (pu_q >= TW'(PU_READ));
  assign wr_ok = (pu_q >= TW'(PU_WRITE));
  // ready in idle, or between page loads once the least spacing passed
  assign ready_o = ((st_q == PEBAC_IDLE) && rd_ok && (!we_i || wr_ok))
                   || ((st_q == PEBAC_WR_GAP) && we_i && (win_q >= TW'(LOAD_MIN_CYC)));
  assign busy_o = (st_q == PEBAC_BUSY) || (st_q == PEBAC_POLL_ACC) || (st_q == PEBAC_POLL_REL);

  // next state and pin values
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wd_d = wd_q;
    last_wd_d = last_wd_q;
    rd_d = rd_q;
    sel_n_d = sel_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dqoe_d = dqoe_q;
    rv_d = 1'b0;
    page_d = page_q;
    close_d = close_q;
    poll_d = poll_q;
    win_d = (win_q == {TW{1'b1}}) ? win_q : win_q + 1'b1;
    pu_d = (pu_q == {TW{1'b1}}) ? pu_q : pu_q + 1'b1;
    load = 1'b0;
    tval = '0;
    case (st_q)
      PEBAC_IDLE, PEBAC_WR_GAP: begin
        // page closes if the longest spacing runs out
        // page_q is only set while a page stands open between loads
        if (page_q && win_q >= TW'(LOAD_MAX_CYC - STROBE_CYC)) begin
          st_d = PEBAC_BUSY;
          load = 1'b1;
          tval = TW'(WRITE_WAIT);
          page_d = 1'b0;
        end else if (req_i && ready_o) begin
          addr_d = addr_i;
          sel_n_d = 1'b0;
          if (we_i) begin
            wd_d = wdata_i;
            last_wd_d = wdata_i;
            oe_n_d = 1'b1;
            dqoe_d = 1'b1;
            // the last byte of a page always closes it, even as the first load
            close_d = last_i || (addr_i[$clog2(PAGE_BYTES)-1:0] ==
                      $clog2(PAGE_BYTES)'(PAGE_BYTES - 1));
            st_d = PEBAC_WR_SETUP;
            load = 1'b1;
            tval = TW'(SETUP_CYC);
          end else begin
            oe_n_d = 1'b0;
            poll_d = 1'b0;
            st_d = PEBAC_RD_ACC;
            load = 1'b1;
            tval = TW'(ACCESS_CYC + 2);
          end
        end
      end
      PEBAC_RD_ACC, PEBAC_POLL_ACC: begin
        // wait access time plus synchroniser delay
        if (tdone) begin
          rd_d = dq_s2_q;
          sel_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d = (st_q == PEBAC_RD_ACC) ? PEBAC_RD_REL : PEBAC_POLL_REL;
          load = 1'b1;
          tval = TW'(RELEASE_CYC);
          rv_d = !poll_q; // polls raise no read pulse
        end
      end
      PEBAC_RD_REL: begin
        // device lets go of the bus before anything else drives it
        if (tdone) st_d = PEBAC_IDLE;
      end
      PEBAC_WR_SETUP: begin
        // drive high setup, then strobe low
        if (tdone) begin
          we_n_d = 1'b0;
          st_d = PEBAC_WR_PULSE;
          load = 1'b1;
          tval = TW'(STROBE_CYC);
        end
      end
      PEBAC_WR_PULSE: begin
        if (tdone) begin
          we_n_d = 1'b1;
          win_d = '0;
          st_d = PEBAC_WR_HOLD;
          load = 1'b1;
          tval = TW'(RECOVERY_CYC);
        end
      end
      PEBAC_WR_HOLD: begin
        // data and drive held through recovery, then release
        if (tdone) begin
          sel_n_d = 1'b1;
          dqoe_d = 1'b0;
          if (close_q) begin
            st_d = PEBAC_BUSY;
            page_d = 1'b0;
            load = 1'b1;
            tval = TW'(WRITE_WAIT);
          end else begin
            page_d = 1'b1;
            st_d = PEBAC_WR_GAP;
          end
        end
      end
      PEBAC_BUSY: begin
        // wait full internal write, or poll until data matches
        if (tdone) begin
          st_d = PEBAC_IDLE;
        end else if (USE_POLL && win_q >= TW'(LOAD_MAX_CYC)) begin
          sel_n_d = 1'b0;
          oe_n_d = 1'b0;
          poll_d = 1'b1;
          st_d = PEBAC_POLL_ACC;
          load = 1'b1;
          tval = TW'(ACCESS_CYC + 2);
        end
      end
      PEBAC_POLL_REL: begin
        if (tdone) begin
          win_d = '0;
          if (rd_q == last_wd_q) begin
            st_d = PEBAC_IDLE;
          end else begin
            st_d = PEBAC_BUSY;
            load = 1'b1;
            tval = TW'(WRITE_WAIT);
          end
        end
      end
      default: begin
        st_d = PEBAC_IDLE;
      end
    endcase
  end

  // register state and pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= PEBAC_IDLE;
      addr_q <= '0;
      wd_q <= '0;
      last_wd_q <= '0;
      rd_q <= '0;
      sel_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dqoe_q <= 1'b0;
      rv_q <= 1'b0;
      page_q <= 1'b0;
      close_q <= 1'b0;
      poll_q <= 1'b0;
      win_q <= '0;
      pu_q <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      last_wd_q <= last_wd_d;
      rd_q <= rd_d;
      sel_n_q <= sel_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dqoe_q <= dqoe_d;
      rv_q <= rv_d;
      page_q <= page_d;
      close_q <= close_d;
      poll_q <= poll_d;
      win_q <= win_d;
      pu_q <= pu_d;
    end
  end

  assign mem_addr_o = addr_q;
  assign mem_sel_n_o = sel_n_q;
  assign mem_oe_n_o = oe_n_q;
  assign mem_we_n_o = we_n_q;
  assign mem_dq_o = wd_q;
  assign mem_dq_oe_o = dqoe_q;
  assign rdata_o = rd_q;
  assign rvalid_o = rv_q;
endmodule

// File: pebac_host_asserts.sv
// Purpose: pin timing checks for the eeprom host controller
// Assumes: one clock, async active-high reset
// Notes: bound to the controller below
`timescale 1ns/1ps
module pebac_host_asserts
  import pebac_pkg::*;
#(
  parameter int PU_READ = 5, // power-up to read, cycles
  parameter int PU_WRITE = 10 // power-up to write, cycles
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic req_i, // request valid
  input wire logic we_i, // write request
  input wire logic ready_o, // request taken
  input wire logic rvalid_o, // read data pulse
  input wire logic busy_o, // internal write
  input wire logic [15:0] mem_addr_o, // address pins
  input wire logic mem_sel_n_o, // select
  input wire logic mem_oe_n_o, // output drive
  input wire logic mem_we_n_o, // write strobe
  input wire logic mem_dq_oe_o // host drives data
);
  logic [4:0] acc_q, acc_d; // cycles with select and drive low
  logic [4:0] gap_q, gap_d; // cycles since strobe rise, saturating
  logic [19:0] up_q, up_d; // cycles since reset, saturating
  // next counts
  always_comb begin
    acc_d = (!mem_sel_n_o && !mem_oe_n_o) ? acc_q + 5'h1 : 5'h0;
    gap_d = !mem_we_n_o ? 5'h0 : gap_q + 5'(gap_q != 5'h1f);
    up_d = up_q + 20'(up_q != 20'hfffff);
  end
  // count registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 5'h0;
      gap_q <= 5'h1f;
      up_q <= 20'h0;
    end else begin
      acc_q <= acc_d;
      gap_q <= gap_d;
      up_q <= up_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_wr_form; !mem_we_n_o |-> mem_oe_n_o && !mem_sel_n_o && mem_dq_oe_o; endproperty
  a_wr_form: assert property (p_wr_form) else $error("strobe low outside a write");
  property p_strobe; $fell(mem_we_n_o) |-> (!mem_we_n_o)[*8] ##1 (!mem_we_n_o)[*2]; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pulse too short");
  property p_setup; $fell(mem_we_n_o) |-> $past(mem_oe_n_o) && $past(mem_dq_oe_o); endproperty
  a_setup: assert property (p_setup) else $error("strobe fell without setup");
  property p_hold; !mem_we_n_o |=> $stable(mem_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("address moved during strobe");
  property p_clash; !mem_oe_n_o |-> !mem_dq_oe_o; endproperty
  a_clash: assert property (p_clash) else $error("host drives data during a read");
  property p_release; $rose(mem_oe_n_o) |-> (!mem_dq_oe_o)[*5]; endproperty
  a_release: assert property (p_release) else $error("host drove before release");
  property p_rd_wait; rvalid_o |-> acc_q >= 5'(ACCESS_CYC + 2); endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read data taken too early");
  property p_gap; $fell(mem_we_n_o) |-> gap_q >= 5'(LOAD_MIN_CYC); endproperty
  a_gap: assert property (p_gap) else $error("byte loads too close");
  property p_busy; busy_o |-> !ready_o && mem_we_n_o; endproperty
  a_busy: assert property (p_busy) else $error("write during internal write");
  property p_pu_rd; ready_o |-> up_q >= 20'(PU_READ - 1); endproperty
  a_pu_rd: assert property (p_pu_rd) else $error("request before power-up read wait");
  property p_pu_wr; req_i && we_i && ready_o |-> up_q >= 20'(PU_WRITE - 1); endproperty
  a_pu_wr: assert property (p_pu_wr) else $error("write before power-up write wait");
endmodule
bind pebac_host pebac_host_asserts #(.PU_READ(PU_READ), .PU_WRITE(PU_WRITE)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
  .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_sel_n_o(mem_sel_n_o), .mem_oe_n_o(mem_oe_n_o),
  .mem_we_n_o(mem_we_n_o), .mem_dq_oe_o(mem_dq_oe_o)
);

// File: pebac_pkg.sv
// Purpose: shared constants for the parallel eeprom host controller
// Assumes: 100 MHz system clock, 10 ns period
// Notes: times kept in their printed unit, cycle counts derived here
package pebac_pkg;
  localparam int CLK_PERIOD_PS = 10000; // clock period in ps
  // read timing, ns
  localparam int ADDR_ACCESS_NS = 150; // address or select to data
  localparam int OUTPUT_ACCESS_TIME_NS = 80; // drive low to data
  localparam int SELECT_RELEASE_TIME_NS = 50; // select high to release
  localparam int DRIVE_RELEASE_TIME_NS = 50; // drive high to release
  // write timing, ns
  localparam int STROBE_WIDTH_NS = 100; // strobe low pulse width
  localparam int STROBE_RECOVERY_NS = 100; // strobe high recovery
  localparam int DRIVE_SETUP_NS = 10; // drive high setup and hold
  localparam int ADDR_HOLD_NS = 50; // address hold after strobe fall
  // byte load window, ns
  localparam int BYTE_LOAD_WINDOW_MIN_NS = 200; // least spacing
  localparam int BYTE_LOAD_WINDOW_MAX_NS = 100000; // longest spacing
  // long times
  localparam int INTERNAL_WRITE_TIME_MS = 5; // self-timed write
  localparam int POWERUP_READ_US = 100; // power-up to read
  localparam int POWERUP_WRITE_MS = 5; // power-up to write
  // cycle counts: least times rounded up, longest rounded down
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OE_ACCESS_CYC = (OUTPUT_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELEASE_CYC = (DRIVE_RELEASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC = (STROBE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVERY_CYC = (STROBE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (DRIVE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOAD_MIN_CYC = (BYTE_LOAD_WINDOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOAD_MAX_CYC = (BYTE_LOAD_WINDOW_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int WRITE_WAIT_CYC = INTERNAL_WRITE_TIME_MS * 100000; // 5 ms at 100 MHz
  localparam int PU_READ_CYC = POWERUP_READ_US * 100; // 100 us at 100 MHz
  localparam int PU_WRITE_CYC = POWERUP_WRITE_MS * 100000; // 5 ms at 100 MHz
  // controller states
  typedef enum logic [3:0] {
    PEBAC_IDLE = 4'h0,
    PEBAC_RD_ACC = 4'h1,
    PEBAC_RD_REL = 4'h2,
    PEBAC_WR_SETUP = 4'h3,
    PEBAC_WR_PULSE = 4'h4,
    PEBAC_WR_HOLD = 4'h5,
    PEBAC_WR_GAP = 4'h6,
    PEBAC_BUSY = 4'h7,
    PEBAC_POLL_ACC = 4'h8,
    PEBAC_POLL_REL = 4'h9
  } pebac_state_t;
endpackage

// File: pebac_timer.sv
// Purpose: loadable down counter used for the controller's state delays; power-up and load spacing use their own counts
// Assumes: load and count come from the same clock domain
// Notes: done is high while the count stands at zero
`timescale 1ns/1ps
module pebac_timer #(
  parameter int W = 20 // counter width
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic load_i, // load a new count
  input wire logic [W-1:0] value_i, // count to load
  output logic done_o // count reached zero
);
  logic [W-1:0] cnt_q; // remaining cycles
  logic [W-1:0] cnt_d; // next count

  initial begin
    if (W < 2) $error("pebac_timer: width too small");
  end

  // next count: load wins, else count toward zero
  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = value_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // register the count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_o = (cnt_q == '0);
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for the eeprom host controller
// Assumes: device model on the pins; short power-up and wait counts
// Notes: page closing on a boundary, single byte, read back
`timescale 1ns/1ps
module tb_top;
  import pebac_pkg::*;
  logic clk_i = 1'b0; // clock
  logic rst_i = 1'b1; // reset
  logic req_i = 1'b0; // request valid
  logic we_i = 1'b0; // write request
  logic last_i = 1'b0; // closes the page
  logic [15:0] addr_i = 16'h0; // request address
  logic [7:0] wdata_i = 8'h0; // write data
  logic ready_o, rvalid_o, busy_o, sel_n, oe_n, we_n, dq_oe; // controller outputs
  logic [7:0] rdata_o, dq_o, dev_dq, bus; // data paths
  logic [15:0] maddr, wa; // address pins, random write address
  logic [7:0] shadow [logic [15:0]]; // expected contents
  int n_errors = 0; // mismatches
  int checked = 0; // comparisons
  assign bus = dq_oe ? dq_o : dev_dq; // host wins while it drives
  always #5 clk_i = ~clk_i;
  // write wait outlasts the model's close window plus its write, so polling ends busy
  pebac_host #(.WRITE_WAIT(15000), .PU_READ(5), .PU_WRITE(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i), .last_i(last_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .busy_o(busy_o),
    .mem_addr_o(maddr), .mem_sel_n_o(sel_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n),
    .mem_dq_i(bus), .mem_dq_o(dq_o), .mem_dq_oe_o(dq_oe));
  pebac_eeprom_model model (.addr_i(maddr), .sel_n_i(sel_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_i(bus), .dq_o(dev_dq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hold the request until ready is seen, then release after the taking edge
  task automatic host_op(input logic w, input logic l, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = w;
    last_i = l;
    addr_i = a;
    wdata_i = d;
    for (int k = 0; k < 30000 && ready_o !== 1'b1; k++) @(negedge clk_i);
    check(16'(ready_o), 16'h1);
    @(negedge clk_i);
    req_i = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic l);
    host_op(1'b1, l, a, d);
    shadow[a] = d;
  endtask
  task automatic rd(input logic [15:0] a);
    host_op(1'b0, 1'b0, a, 8'h0);
    for (int k = 0; k < 40 && rvalid_o !== 1'b1; k++) @(negedge clk_i);
    check(16'(rvalid_o), 16'h1);
    check(16'(rdata_o), 16'(shadow.exists(a) ? shadow[a] : 8'hff));
  endtask
  // busy rises after the page closes, and ends by polling
  task automatic page_end;
    for (int k = 0; k < 12000 && busy_o !== 1'b1; k++) @(negedge clk_i);
    check(16'(busy_o), 16'h1);
    check(16'(ready_o), 16'h0);
    for (int k = 0; k < 50000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    check(16'(busy_o), 16'h0);
  endtask
  initial begin
    void'($urandom(32'hf9ce));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check(16'(ready_o), 16'h0);
    for (int i = 0; i < 4; i++) wr(16'h0a7c + 16'(i), 8'($urandom), 1'b0);
    page_end();
    wa = 16'($urandom);
    wr(wa, 8'($urandom), 1'b1);
    page_end();
    // a page left open closes when its load window lapses
    wr(16'h0b10, 8'($urandom), 1'b0);
    page_end();
    for (int i = 0; i < 5; i++) rd(16'h0a7b + 16'(i));
    rd(wa);
    rd(16'h0b10);
    repeat (3) rd(16'($urandom));
    final_report();
  end
  // cut a hang short
  initial begin
    #900us;
    n_errors++;
    final_report();
  end
endmodule
